//--- pkg/csp_pkg.sv
// constants and types of the clocked serial port
`default_nettype none
package csp_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [31:0] ADDR_CH0_SERIAL_CONTROL0 = 32'h0ffffd00;
  localparam logic [31:0] ADDR_CH1_SERIAL_CONTROL0 = 32'h0ffffd10;
  localparam logic [31:0] ADDR_CH2_SERIAL_CONTROL0 = 32'h0ffffd20;
  localparam logic [31:0] ADDR_CH3_SERIAL_CONTROL0 = 32'h0ffffd30;
  localparam logic [31:0] ADDR_CH4_SERIAL_CONTROL0 = 32'h0ffffd40;
  localparam logic [7:0] OFS_SERIAL_CONTROL0 = 8'h00;
  localparam logic [7:0] OFS_RECEIVE_BUFFER = 8'h04;
  localparam logic [7:0] OFS_TRANSMIT_BUFFER = 8'h08;
  localparam logic [7:0] OFS_WORD_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_RECEIVE_BUFFER_LOW_BYTE = 8'h10;
  localparam logic [7:0] OFS_TRANSMIT_BUFFER_LOW_BYTE = 8'h14;

  // ***************************************************************
  // fields of serial_control0
  // ***************************************************************
  localparam int POS_POWER_ENABLE = 7;
  localparam int POS_TRANSMIT_ENABLE = 6;
  localparam int POS_RECEIVE_ENABLE = 5;
  localparam int POS_BIT_ORDER_SELECT = 4;
  localparam int POS_TRANSFER_MODE_SELECT = 1;
  localparam int POS_CLOCK_EDGE_SELECT = 0;
  localparam logic [7:0] CTL0_LOCKED_MASK = 8'h72;
  localparam logic [7:0] CTL0_WRITE_MASK = 8'hf3;

  // ***************************************************************
  // word config register
  // ***************************************************************
  localparam int POS_BUSY = 8;
  localparam logic [3:0] LEN_CODE_MAX = 4'h8;
  localparam logic [4:0] LEN_BASE_BITS = 5'h08;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_SERIAL_CONTROL0 = 8'h01;
  localparam logic [15:0] RST_BUFFER = 16'h0000;
  localparam logic [3:0] RST_LEN_CODE = 4'h0;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam longint CORE_CLK_HZ = 250000000;
  localparam longint SCK_MAX_RATE_HZ = 8000000;
  localparam int SCK_HALF_CYCLES =
    int'((CORE_CLK_HZ + 2 * SCK_MAX_RATE_HZ - 1) / (2 * SCK_MAX_RATE_HZ));

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    CSP_IDLE = 2'b00,
    CSP_LEAD = 2'b01,
    CSP_TRAIL = 2'b11
  } csp_phase_e;

endpackage
`default_nettype wire

//--- hdl/csp_serial_port.sv
// one channel of the clocked serial port with its apb register slave
`default_nettype none

// Operation
// - receive buffer: 16-bit, read-only word
// - reset clears both data buffers
// - reading receive buffer starts reception if receive-only
// - low receive byte view in 8-bit mode
// - power off clears receive buffer
// - transmit buffer: 16-bit read/write word
// - writing transmit buffer starts transmission
// - low transmit byte read view, 8-bit mode
// - start by write, or read if receive-only
// - control0 written bytewise, bits via software
// - control0 resets to 01h
// - power off holds engine and status reset
// - data out low while transmit disabled
// - receive disabled: no interrupt, buffer kept
// - power on together with mode bits accepted
// - abort stops serial clock at once
// - word length 8 to 16 bits
// - separate transmit and receive interrupts
// - bit order msb or lsb first
module csp_serial_port
  import csp_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = ADDR_CH0_SERIAL_CONTROL0,
  parameter int HALF_CYCLES = SCK_HALF_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_CLOCK_LINE,
  output logic TRANSMIT_INTERRUPT,
  output logic RECEIVE_INTERRUPT
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] ctl0;
    logic [3:0] len_code;
    logic [15:0] tx_buf;
    logic [15:0] rx_buf;
    logic [15:0] rx_shift;
    logic busy;
    csp_phase_e phase;
    logic [15:0] div_cnt;
    logic [4:0] bit_idx;
    logic sck;
    logic so;
    logic tx_irq;
    logic rx_irq;
    logic si_s1;
    logic si_s2;
  } csp_state_s;

  localparam csp_state_s RST_STATE = '{
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h00000000,
    ctl0: RST_SERIAL_CONTROL0,
    len_code: RST_LEN_CODE,
    tx_buf: RST_BUFFER,
    rx_buf: RST_BUFFER,
    rx_shift: RST_BUFFER,
    busy: 1'b0,
    phase: CSP_IDLE,
    div_cnt: 16'h0000,
    bit_idx: 5'h00,
    sck: RST_SERIAL_CONTROL0[POS_CLOCK_EDGE_SELECT],
    so: 1'b0,
    tx_irq: 1'b0,
    rx_irq: 1'b0,
    si_s1: 1'b0,
    si_s2: 1'b0
  };

  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1);

  csp_state_s st_reg;
  csp_state_s st_next;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // word length in bits, codes above the top clamp to 16
  function automatic logic [4:0] word_len(input logic [3:0] code);
    logic [3:0] c;
    c = (code > LEN_CODE_MAX) ? LEN_CODE_MAX : code;
    return LEN_BASE_BITS + {1'b0, c};
  endfunction

  // buffer bit that belongs to serial step idx
  function automatic logic [3:0] bit_pos(input logic lsb_first,
                                         input logic [4:0] len,
                                         input logic [4:0] idx);
    logic [4:0] p;
    p = lsb_first ? idx : 5'(len - idx - 5'h01);
    return p[3:0];
  endfunction

  // register select: offset match from the channel base
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [7:0] ofs);
    return (addr - BASE_ADDR) == {24'h000000, ofs};
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  logic access;
  logic pwr;
  logic txe;
  logic rxe;
  logic dir;
  logic sce;
  logic len8;
  logic [4:0] len;
  logic hit_ctl0;
  logic hit_rx;
  logic hit_tx;
  logic hit_cfg;
  logic hit_rxl;
  logic hit_txl;
  logic mapped;
  logic bad;
  logic start;
  logic [7:0] wb;
  logic [31:0] rdata;
  logic last_bit;
  logic [3:0] pos;

  always_comb begin
    st_next = st_reg;
    st_next.tx_irq = 1'b0;
    st_next.rx_irq = 1'b0;
    st_next.si_s1 = SERIAL_DATA_IN;
    st_next.si_s2 = st_reg.si_s1;

    access = PSEL & PENABLE;
    pwr = st_reg.ctl0[POS_POWER_ENABLE];
    txe = st_reg.ctl0[POS_TRANSMIT_ENABLE];
    rxe = st_reg.ctl0[POS_RECEIVE_ENABLE];
    dir = st_reg.ctl0[POS_BIT_ORDER_SELECT];
    sce = st_reg.ctl0[POS_CLOCK_EDGE_SELECT];
    len = word_len(st_reg.len_code);
    len8 = (len == LEN_BASE_BITS);
    hit_ctl0 = reg_hit(PADDR, OFS_SERIAL_CONTROL0);
    hit_rx = reg_hit(PADDR, OFS_RECEIVE_BUFFER);
    hit_tx = reg_hit(PADDR, OFS_TRANSMIT_BUFFER);
    hit_cfg = reg_hit(PADDR, OFS_WORD_CONFIG);
    hit_rxl = reg_hit(PADDR, OFS_RECEIVE_BUFFER_LOW_BYTE);
    hit_txl = reg_hit(PADDR, OFS_TRANSMIT_BUFFER_LOW_BYTE);
    mapped = hit_ctl0 | hit_rx | hit_tx | hit_cfg | hit_rxl | hit_txl;
    // byte views exist only for 8-bit words; read-only views
    bad = ~mapped | ((hit_rxl | hit_txl) & ~len8) |
          (PWRITE & (hit_rx | hit_rxl | hit_txl));
    start = 1'b0;
    wb = PWDATA[7:0];
    last_bit = 1'b0;
    pos = bit_pos(dir, len, st_reg.bit_idx);

    // read data mux
    rdata = 32'h00000000;
    if (hit_ctl0) begin
      rdata = {24'h000000, st_reg.ctl0};
    end else if (hit_rx) begin
      rdata = {16'h0000, st_reg.rx_buf};
    end else if (hit_tx) begin
      rdata = {16'h0000, st_reg.tx_buf};
    end else if (hit_cfg) begin
      rdata = {23'h0, st_reg.busy, 4'h0, st_reg.len_code};
    end else if (hit_rxl) begin
      rdata = {24'h000000, st_reg.rx_buf[7:0]};
    end else if (hit_txl) begin
      rdata = {24'h000000, st_reg.tx_buf[7:0]};
    end
    if (bad) begin
      rdata = 32'h00000000;
    end

    // *************************************************************
    // apb: one wait state, effects at the completing edge
    // *************************************************************
    if (access & ~st_reg.pready) begin
      st_next.pready = 1'b1;
      st_next.pslverr = bad;
      st_next.prdata = PWRITE ? 32'h00000000 : rdata;
    end else if (access & st_reg.pready) begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      if (~bad & PWRITE) begin
        if (hit_ctl0 & PSTRB[0]) begin
          if (pwr) begin
            // enable, bit order and transfer mode bits locked while powered; power and clock edge stay writable
            st_next.ctl0 = (st_reg.ctl0 & CTL0_LOCKED_MASK) |
                           (wb & ~CTL0_LOCKED_MASK & CTL0_WRITE_MASK);
          end else begin
            st_next.ctl0 = wb & CTL0_WRITE_MASK;
          end
        end
        if (hit_tx) begin
          if (PSTRB[0]) begin
            st_next.tx_buf[7:0] = PWDATA[7:0];
          end
          if (PSTRB[1]) begin
            st_next.tx_buf[15:8] = PWDATA[15:8];
          end
          start = pwr & txe & ~st_reg.busy;
        end
        if (hit_cfg & PSTRB[0]) begin
          st_next.len_code = PWDATA[3:0];
        end
      end else if (~bad & (hit_rx | hit_rxl)) begin
        start = pwr & rxe & ~txe & ~st_reg.busy;
      end
    end else begin
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
    end

    // *************************************************************
    // shift engine
    // *************************************************************
    if (start) begin
      st_next.busy = 1'b1;
      st_next.phase = CSP_LEAD;
      st_next.div_cnt = 16'h0000;
      st_next.bit_idx = 5'h00;
      st_next.rx_shift = RST_BUFFER;
      st_next.so = st_next.tx_buf[bit_pos(dir, len, 5'h00)];
    end else if (st_reg.busy) begin
      if (st_reg.div_cnt == HALF_LAST) begin
        st_next.div_cnt = 16'h0000;
        unique case (st_reg.phase)
          CSP_LEAD: begin
            st_next.sck = ~sce;
            st_next.phase = CSP_TRAIL;
          end
          CSP_TRAIL: begin
            st_next.sck = sce;
            st_next.rx_shift[pos] = st_reg.si_s2;
            last_bit = (st_reg.bit_idx == 5'(len - 5'h01));
            if (last_bit) begin
              st_next.busy = 1'b0;
              st_next.phase = CSP_IDLE;
              st_next.tx_irq = txe;
              if (rxe) begin
                st_next.rx_buf = st_next.rx_shift;
                st_next.rx_irq = 1'b1;
              end
            end else begin
              st_next.bit_idx = st_reg.bit_idx + 5'h01;
              st_next.phase = CSP_LEAD;
              st_next.so = st_reg.tx_buf[bit_pos(dir, len,
                             5'(st_reg.bit_idx + 5'h01))];
            end
          end
          default: begin
            st_next.busy = 1'b0;
            st_next.phase = CSP_IDLE;
          end
        endcase
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 16'h0001;
      end
    end

    // *************************************************************
    // power off: engine and status held in reset
    // *************************************************************
    // a power-off write stops the engine at its own edge
    if (~st_next.ctl0[POS_POWER_ENABLE]) begin
      st_next.busy = 1'b0;
      st_next.phase = CSP_IDLE;
      st_next.div_cnt = 16'h0000;
      st_next.bit_idx = 5'h00;
      st_next.rx_shift = RST_BUFFER;
      st_next.rx_buf = RST_BUFFER;
      st_next.sck = st_next.ctl0[POS_CLOCK_EDGE_SELECT];
      st_next.tx_irq = 1'b0;
      st_next.rx_irq = 1'b0;
    end else if (~st_next.busy) begin
      st_next.sck = st_next.ctl0[POS_CLOCK_EDGE_SELECT];
    end
    if (~st_next.ctl0[POS_TRANSMIT_ENABLE] | ~st_next.busy) begin
      st_next.so = 1'b0;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign SERIAL_DATA_OUT = st_reg.so;
  assign SERIAL_CLOCK_LINE = st_reg.sck;
  assign TRANSMIT_INTERRUPT = st_reg.tx_irq;
  assign RECEIVE_INTERRUPT = st_reg.rx_irq;

endmodule
`default_nettype wire

//--- tb/csp_serial_port_checker.sv
// assertions on the pins and bus of the serial port
`default_nettype none
module csp_serial_port_checker
  import csp_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = ADDR_CH0_SERIAL_CONTROL0
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_CLOCK_LINE,
  input wire logic TRANSMIT_INTERRUPT,
  input wire logic RECEIVE_INTERRUPT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bus and pin checks
  // ****
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic [31:0] ofs;
  logic acc;
  logic rd;
  assign ofs = PADDR - BASE_ADDR;
  assign acc = PSEL && PENABLE;
  assign rd = PREADY && !PWRITE;
  wait_state_a: assert property (acc && !PREADY |=> PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  reset_state_a: assert property ($fell(RESET) |->
    SERIAL_CLOCK_LINE && !PREADY && !SERIAL_DATA_OUT
    && !TRANSMIT_INTERRUPT && !RECEIVE_INTERRUPT)
    else $error("bad state after reset");
  tx_pulse_a: assert property (
    TRANSMIT_INTERRUPT |=> !TRANSMIT_INTERRUPT)
    else $error("tx irq too long");
  rx_pulse_a: assert property (
    RECEIVE_INTERRUPT |=> !RECEIVE_INTERRUPT)
    else $error("rx irq too long");
  err_ready_a: assert property (PSLVERR |-> PREADY && acc)
    else $error("error without ready");
  upper_zero_a: assert property (
    rd |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  ctl_zero_a: assert property (
    rd && ofs == {24'h0, OFS_SERIAL_CONTROL0} |->
    PRDATA[31:8] == 24'h0 && PRDATA[3:2] == 2'b00)
    else $error("ctl zeros");
  rx_write_a: assert property (
    PREADY && PWRITE && ofs == {24'h0, OFS_RECEIVE_BUFFER} |-> PSLVERR)
    else $error("rx buffer written");
  unmapped_a: assert property (PREADY && ofs > 32'h14 |-> PSLVERR)
    else $error("unmapped accepted");
endmodule
bind csp_serial_port csp_serial_port_checker #(.BASE_ADDR(BASE_ADDR)) chk_inst (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .SERIAL_CLOCK_LINE(SERIAL_CLOCK_LINE),
  .TRANSMIT_INTERRUPT(TRANSMIT_INTERRUPT),
  .RECEIVE_INTERRUPT(RECEIVE_INTERRUPT));
`default_nettype wire

//--- tb/csp_peer.sv
// serial peer on the link: captures data out, answers on data in
`default_nettype none
module csp_peer (
  input wire logic clk,
  input wire logic clr,
  input wire logic idle,
  input wire logic sck,
  input wire logic so,
  input wire logic [15:0] seq,
  output logic si,
  output logic [15:0] got,
  output int cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bit exchange
  // ****
  logic trail = 0;
  initial si = 0;
  initial got = 0;
  initial cnt = 0;
  always @(posedge clk) begin
    trail <= sck !== idle;
    if (clr) begin
      got <= 0;
      cnt <= 0;
    end else if (sck !== idle && !trail) begin
      got[cnt[3:0]] <= so;
      cnt <= cnt + 1;
    end
    // released line toggles so a stale bit never passes
    if (sck === idle) si <= ~si;
    else si <= trail ? seq[4'(cnt - 1)] : seq[cnt[3:0]];
  end
endmodule
`default_nettype wire

//--- tb/csp_serial_port_tb.sv
// bench for one serial port channel with a peer on the link
`default_nettype none
module csp_serial_port_tb;
  import csp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, clr = 0, idle = 1;
  logic [31:0] pa = 0, pd = 0, r, prd, old;
  logic pr, perr, e, si, so, sck, tirq, rirq;
  logic [15:0] seq = 0, got, rnd = 16'h0012, d, s;
  logic [7:0] m_ctl = 8'h01;
  int failures = 0, comparisons = 0, cyc = 0, cnt, k;
  int ntx = 0, nrx = 0, etx = 0, erx = 0;
  always #2 clk = ~clk;
  csp_serial_port #(.HALF_CYCLES(20)) csp_serial_port_inst (
    .CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pw),
    .PADDR(pa), .PWDATA(pd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(pr),
    .PSLVERR(perr), .SERIAL_DATA_IN(si), .SERIAL_DATA_OUT(so),
    .SERIAL_CLOCK_LINE(sck), .TRANSMIT_INTERRUPT(tirq),
    .RECEIVE_INTERRUPT(rirq));
  csp_peer csp_peer_inst (.clk(clk), .clr(clr), .idle(idle), .sck(sck),
    .so(so), .seq(seq), .si(si), .got(got), .cnt(cnt));
  // ****
  // helpers
  // ****
  always @(posedge clk) begin
    cyc++;
    ntx += tirq === 1'b1;
    nrx += rirq === 1'b1;
    if (cyc > 40000) begin
      failures++;
      $display("unexpected %0t: timeout", $time);
      report_and_stop;
    end
  end
  function automatic logic [31:0] ro(input logic [15:0] x, input int n,
                                     input logic l);
    ro = 0;
    for (int i = 0; i < n; i++) ro[i] = l ? x[i] : x[n - 1 - i];
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("unexpected %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] v);
    psel <= 1;
    pw <= w;
    pa <= ADDR_CH0_SERIAL_CONTROL0 + {24'h0, o};
    pd <= v;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pr !== 1'b1);
    r = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic ctl(input logic [7:0] v);
    if (m_ctl[POS_POWER_ENABLE])
      m_ctl = m_ctl & CTL0_LOCKED_MASK
              | v & ~CTL0_LOCKED_MASK & CTL0_WRITE_MASK;
    else m_ctl = v & CTL0_WRITE_MASK;
    bus(1, OFS_SERIAL_CONTROL0, {24'h0, v});
    bus(0, OFS_SERIAL_CONTROL0, 0);
    chk(r, {24'h0, m_ctl});
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic prep;
    rnd = lfsr(rnd);
    s = rnd;
    d = {rnd[7:0], rnd[15:8]} ^ 16'h5a3c;
    seq <= s;
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    @(posedge clk);
  endtask
  task automatic wt;
    do begin
      bus(0, OFS_WORD_CONFIG, 0);
    end while (r[POS_BUSY] !== 1'b0);
  endtask
  task automatic xfer(input logic l, input logic w16);
    int n;
    n = w16 ? 16 : 8;
    ctl(m_ctl & 8'h7f);
    bus(1, OFS_WORD_CONFIG, w16 ? {28'h0, LEN_CODE_MAX} : 0);
    ctl({3'b111, l, 3'b001, l});
    idle <= l;
    prep;
    bus(1, OFS_TRANSMIT_BUFFER, {16'h0, d});
    wt;
    etx++;
    erx++;
    chk(cnt, n);
    chk({16'h0, got}, ro(d, n, l));
    bus(0, OFS_RECEIVE_BUFFER, 0);
    chk(r, ro(s, n, l));
    chk(ntx, etx);
    chk(nrx, erx);
    if (!w16) begin
      bus(0, OFS_RECEIVE_BUFFER_LOW_BYTE, 0);
      chk(r, ro(s, 8, l));
      bus(0, OFS_TRANSMIT_BUFFER_LOW_BYTE, 0);
      chk(r, {24'h0, d[7:0]});
      bus(1, OFS_TRANSMIT_BUFFER_LOW_BYTE, 0);
      chk(e, 1);
    end else begin
      bus(0, OFS_RECEIVE_BUFFER_LOW_BYTE, 0);
      chk(e, 1);
    end
  endtask
  task automatic report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    bus(0, OFS_SERIAL_CONTROL0, 0);
    chk(r, {24'h0, RST_SERIAL_CONTROL0});
    bus(0, OFS_RECEIVE_BUFFER, 0);
    chk(r, 0);
    bus(0, OFS_TRANSMIT_BUFFER, 0);
    chk(r, 0);
    prep;
    bus(1, OFS_TRANSMIT_BUFFER, {16'h0, d});
    bus(0, OFS_TRANSMIT_BUFFER, 0);
    chk(r, {16'h0, d});
    repeat (100) @(posedge clk);
    chk(cnt, 0);
    bus(0, 8'h40, 0);
    chk(e, 1);
    bus(1, OFS_RECEIVE_BUFFER, 32'hffff);
    chk(e, 1);
    for (k = 0; k < 4; k++) xfer(k[0], k[1]);
    ctl(m_ctl & 8'h7f);
    ctl(8'had);
    idle <= 1;
    prep;
    bus(0, OFS_RECEIVE_BUFFER, 0);
    wt;
    bus(0, OFS_RECEIVE_BUFFER, 0);
    chk(r, ro(s, 16, 0));
    wt;
    erx += 2;
    chk({16'h0, got}, 0);
    chk(nrx, erx);
    ctl(m_ctl & 8'h7f);
    ctl(8'hc1);
    prep;
    bus(0, OFS_RECEIVE_BUFFER, 0);
    chk(r, 0);
    old = r;
    repeat (100) @(posedge clk);
    chk(cnt, 0);
    bus(1, OFS_TRANSMIT_BUFFER, {16'h0, d});
    wt;
    etx++;
    bus(0, OFS_RECEIVE_BUFFER, 0);
    chk(r, old);
    chk(nrx, erx);
    chk(ntx, etx);
    ctl(8'h81);
    prep;
    bus(1, OFS_TRANSMIT_BUFFER, {16'h0, d});
    repeat (60) @(posedge clk);
    ctl(8'h41);
    k = cnt;
    repeat (200) @(posedge clk);
    chk(cnt, k);
    bus(0, OFS_RECEIVE_BUFFER, 0);
    chk(r, 0);
    bus(0, OFS_WORD_CONFIG, 0);
    chk(r[POS_BUSY], 0);
    chk(ntx, etx);
    report_and_stop;
  end
endmodule
`default_nettype wire
